// ---- hw/dcc_consts.vh ----
// Constants for the DAC clock and input port configuration block.
//
// Summary of operation
// (R1) PLL enable set: sample clock is data rate; clear: it is DAC rate.
// (R2) Derive synchronised 1x, 2x, 4x and 8x internal clock strobes.
// (R3) Lock shows on the lock pin and in a read-only status bit.
// (R4) PLL on: VCO ratio is interpolation rate times prescaler 1, 2, 4 or 8.
// (R5) Zero stuffing doubles the VCO ratio once more.
// (R6) Source keeps its data rate inside the allowed range, at most 160 MSPS.
// (R7) Sleep turns off only converter currents; clearing it resumes at once.
// (R8) Power-down stops all logic except the register port.
// (R9) After power-down the controller waits for the filters to flush; this block has no such wait and restarts when the power-down bit clears.
// (R10) Two-port mode captures both ports on each data clock rising edge.
// (R11) PLL off: output-select clear sends data clock to lock pin, else readback pin.
// (R12) PLL on: lock-or-clock picks lock or data clock; pin chosen as with PLL off.
// (R13) One-port: port two bit 14 is channel select, bit 15 word clock out.
// (R14) One-port: each word goes to the channel named by channel select.
// (R15) One-port word clock runs at twice the per-channel rate.
// (R16) Select low loads in-phase, high quadrature, unless the invert bit swaps.
// (R17) PLL off: data clock is sample clock over interpolation, halved for stuffing.
// (R18) PLL on, two-port: data clock equals sample clock frequency.
// (R19) Lock reads high only while locked, low when acquiring or disabled.
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH

// Register byte offsets.
`define DCC_ADDR_CTRL 8'h00
`define DCC_ADDR_STATUS 8'h04
`define DCC_ADDR_INT_STATUS 8'h08
`define DCC_ADDR_INT_MASK 8'h0c

// Control register fields.
`define DCC_CTRL_W 13
`define DCC_CTRL_RST 13'h0000
`define DCC_CTRL_PLL_EN 0
`define DCC_CTRL_INTERP_LSB 1
`define DCC_CTRL_PRESC_LSB 3
`define DCC_CTRL_ZERO_STUFF 5
`define DCC_CTRL_ONE_PORT 6
`define DCC_CTRL_SEL_INVERT 7
`define DCC_CTRL_Q_FIRST 8
`define DCC_CTRL_CLK_TO_READBACK 9
`define DCC_CTRL_LOCK_OR_CLOCK 10
`define DCC_CTRL_SLEEP 11
`define DCC_CTRL_POWER_DOWN 12
`define DCC_CTRL_PLL_FIELDS 6

// Status register fields.
`define DCC_STAT_LOCK 0
`define DCC_STAT_RATIO_LSB 8

// Interrupt status and mask fields.
`define DCC_INT_W 2
`define DCC_INT_RST 2'h0
`define DCC_INT_LOCK_GAIN 0
`define DCC_INT_LOCK_LOSS 1

// Sample clock rising edges counted before lock is declared.
`define DCC_LOCK_EDGES 16'h0100

// Bus encodings.
`define DCC_HTRANS_NONSEQ_BIT 1

`endif

// ---- hw/dcc_one_port_demux.v ----
// Splits the interleaved one-port stream into in-phase and quadrature pairs.
`timescale 1ns/100ps
module dcc_one_port_demux (
  input wire mclk,
  input wire rst,
  input wire flush,
  input wire capture,
  input wire [15:0] word_in,
  input wire channel_select_in,
  input wire sel_invert,
  input wire q_first,
  output reg [15:0] i_word_q,
  output reg [15:0] q_word_q,
  output reg pair_valid_q
);

  reg [15:0] held_q;
  wire to_q;

  // Select low means in-phase, high quadrature; the invert bit swaps them.
  assign to_q = channel_select_in ^ sel_invert; // see (R14) (R16)

  // The first word of a pair is held; the second completes and releases the pair.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      held_q <= 16'h0000;
      i_word_q <= 16'h0000;
      q_word_q <= 16'h0000;
      pair_valid_q <= 1'b0;
    end else if (flush) begin
      held_q <= 16'h0000;
      pair_valid_q <= 1'b0;
    end else if (capture) begin
      if (to_q == q_first) begin
        held_q <= word_in;
        pair_valid_q <= 1'b0;
      end else begin
        i_word_q <= to_q ? held_q : word_in;
        q_word_q <= to_q ? word_in : held_q;
        pair_valid_q <= 1'b1;
      end
    end else begin
      pair_valid_q <= 1'b0;
    end
  end

endmodule

// ---- hw/dcc_rate_divider.v ----
// Rate divider that builds a clock level from sample clock half periods.
`timescale 1ns/100ps
module dcc_rate_divider (
  input wire mclk,
  input wire rst,
  input wire flush,
  input wire half_tick,
  input wire [4:0] half_count,
  output reg clk_q,
  output reg rise_q
);

  reg [4:0] cnt_q;

  // Toggle every half_count half periods; a zero count copies each half tick as a pulse.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'h00;
      clk_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (flush) begin
      cnt_q <= 5'h00;
      clk_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (half_count == 5'h00) begin
      clk_q <= half_tick;
      rise_q <= half_tick & ~clk_q;
    end else if (half_tick) begin
      if (cnt_q + 5'h01 >= half_count) begin
        cnt_q <= 5'h00;
        clk_q <= ~clk_q;
        rise_q <= ~clk_q;
      end else begin
        cnt_q <= cnt_q + 5'h01;
        rise_q <= 1'b0;
      end
    end else begin
      rise_q <= 1'b0;
    end
  end

endmodule

// ---- hw/dcc_top.v ----
// Clock mode control and input port configuration for a dual interpolating DAC.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "dcc_consts.vh"
module dcc_top #(
  parameter [15:0] LOCK_EDGES = `DCC_LOCK_EDGES
) (
  input wire mclk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg irq,
  input wire sample_clock_input,
  input wire [15:0] port1_in,
  input wire [15:0] port2_in,
  output reg lock_clock_pin,
  output reg serial_readback_pin,
  output reg serial_readback_oe_n,
  output reg second_port_bit_fifteen,
  output reg second_port_bit_fifteen_oe_n,
  output reg [15:0] i_word,
  output reg [15:0] q_word,
  output reg word_valid,
  output reg [3:0] rate_strobe,
  output reg dac_output_on,
  output reg digital_active
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Half periods of the sample clock per data clock half period when the PLL is off.
  function [4:0] half_count;
    input [1:0] interp_sel;
    input zero_stuff;
    begin
      half_count = (5'h01 << interp_sel) << zero_stuff;
    end
  endfunction

  // VCO multiple of the input data rate: interpolation times prescaler, doubled for stuffing.
  function [7:0] vco_ratio;
    input [1:0] interp_sel;
    input [1:0] presc_sel;
    input zero_stuff;
    begin
      vco_ratio = ((8'h01 << interp_sel) << presc_sel) << zero_stuff;
    end
  endfunction

  // ****************************************************************
  // Register file and bus slave
  // ****************************************************************

  reg [`DCC_CTRL_W-1:0] ctrl_q;
  reg [`DCC_INT_W-1:0] int_stat_q;
  reg [`DCC_INT_W-1:0] int_mask_q;
  reg wr_pend_q;
  reg rd_pend_q;
  reg [7:0] addr_q;
  reg locked_q;
  reg lock_prev_q;
  reg [31:0] rd_mux;

  wire take;
  wire wr_ctrl;
  wire wr_int_stat;
  wire wr_int_mask;
  wire relock;
  wire [`DCC_INT_W-1:0] int_event;

  // Control field decode.
  wire pll_en = ctrl_q[`DCC_CTRL_PLL_EN];
  wire [1:0] interp_sel = ctrl_q[`DCC_CTRL_INTERP_LSB+1:`DCC_CTRL_INTERP_LSB];
  wire [1:0] presc_sel = ctrl_q[`DCC_CTRL_PRESC_LSB+1:`DCC_CTRL_PRESC_LSB];
  wire zero_stuff = ctrl_q[`DCC_CTRL_ZERO_STUFF];
  wire one_port = ctrl_q[`DCC_CTRL_ONE_PORT];
  wire sel_invert = ctrl_q[`DCC_CTRL_SEL_INVERT];
  wire q_first = ctrl_q[`DCC_CTRL_Q_FIRST];
  wire clk_to_readback = ctrl_q[`DCC_CTRL_CLK_TO_READBACK];
  wire lock_or_clock = ctrl_q[`DCC_CTRL_LOCK_OR_CLOCK];
  wire sleep = ctrl_q[`DCC_CTRL_SLEEP];
  wire power_down = ctrl_q[`DCC_CTRL_POWER_DOWN];

  // An address phase is taken when selected, ready and a transfer is requested.
  assign take = hsel & hready & htrans[`DCC_HTRANS_NONSEQ_BIT];
  assign wr_ctrl = wr_pend_q & (addr_q == `DCC_ADDR_CTRL);
  assign wr_int_stat = wr_pend_q & (addr_q == `DCC_ADDR_INT_STATUS);
  assign wr_int_mask = wr_pend_q & (addr_q == `DCC_ADDR_INT_MASK);

  // Any change of the clock mode fields restarts lock acquisition.
  assign relock = wr_ctrl & (hwdata[`DCC_CTRL_PLL_FIELDS-1:0] != ctrl_q[`DCC_CTRL_PLL_FIELDS-1:0]);

  // Lock events seen one cycle after the lock flag moves.
  assign int_event[`DCC_INT_LOCK_GAIN] = locked_q & ~lock_prev_q;
  assign int_event[`DCC_INT_LOCK_LOSS] = ~locked_q & lock_prev_q;

  // Read data selection; unmapped offsets read as zero.
  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr_q)
      `DCC_ADDR_CTRL: begin
        rd_mux[`DCC_CTRL_W-1:0] = ctrl_q;
      end
      `DCC_ADDR_STATUS: begin
        rd_mux[`DCC_STAT_LOCK] = locked_q; // see (R3)
        if (pll_en) begin
          rd_mux[`DCC_STAT_RATIO_LSB+7:`DCC_STAT_RATIO_LSB] = vco_ratio(interp_sel, presc_sel, zero_stuff); // see (R4) (R5)
        end
      end
      `DCC_ADDR_INT_STATUS: begin
        rd_mux[`DCC_INT_W-1:0] = int_stat_q;
      end
      `DCC_ADDR_INT_MASK: begin
        rd_mux[`DCC_INT_W-1:0] = int_mask_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Writes complete with no wait state; reads insert one wait state so data comes from a flop.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hrdata <= rd_mux;
        hreadyout <= 1'b1;
      end
      if (take) begin
        addr_q <= haddr[7:0];
        wr_pend_q <= hwrite;
        rd_pend_q <= ~hwrite;
        hreadyout <= hwrite;
      end else begin
        wr_pend_q <= 1'b0;
      end
    end
  end

  // Software registers; power-down leaves this port fully usable.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `DCC_CTRL_RST;
      int_mask_q <= `DCC_INT_RST;
      int_stat_q <= `DCC_INT_RST;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata[`DCC_CTRL_W-1:0]; // see (R8)
      end
      if (wr_int_mask) begin
        int_mask_q <= hwdata[`DCC_INT_W-1:0];
      end
      // A new event wins over a write-one clear in the same cycle.
      int_stat_q <= (int_stat_q & ~(wr_int_stat ? hwdata[`DCC_INT_W-1:0] : `DCC_INT_RST)) | int_event;
      irq <= |(int_stat_q & int_mask_q);
    end
  end

  // ****************************************************************
  // Sample clock edges and lock tracking
  // ****************************************************************

  reg samp_prev_q;
  reg [15:0] lock_cnt_q;
  wire samp_rise;
  wire samp_half;

  // The sample clock input is sampled as a synchronous level.
  assign samp_rise = sample_clock_input & ~samp_prev_q;
  assign samp_half = sample_clock_input ^ samp_prev_q;

  // Lock is declared after a run of sample edges and drops when disabled or retuned.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      samp_prev_q <= 1'b0;
      lock_cnt_q <= 16'h0000;
      locked_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end else begin
      samp_prev_q <= sample_clock_input;
      lock_prev_q <= locked_q;
      if (power_down | ~pll_en | relock) begin
        lock_cnt_q <= 16'h0000;
        locked_q <= 1'b0; // see (R19)
      end else if (samp_rise & ~locked_q) begin
        if (lock_cnt_q == LOCK_EDGES - 16'h0001) begin
          locked_q <= 1'b1; // see (R19)
        end else begin
          lock_cnt_q <= lock_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // Internal rate strobes
  // ****************************************************************

  reg [2:0] phase_q;

  // Strobes at 8x, 4x, 2x and 1x of the base rate, all aligned to one phase counter.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_q <= 3'h0;
      rate_strobe <= 4'h0;
    end else if (power_down | relock) begin
      phase_q <= 3'h0;
      rate_strobe <= 4'h0;
    end else if (samp_rise) begin
      phase_q <= phase_q + 3'h1;
      rate_strobe[3] <= 1'b1; // see (R2)
      rate_strobe[2] <= ~phase_q[0];
      rate_strobe[1] <= (phase_q[1:0] == 2'h0);
      rate_strobe[0] <= (phase_q == 3'h0);
    end else begin
      rate_strobe <= 4'h0;
    end
  end

  // ****************************************************************
  // Data rate clock and interleaved word clock
  // ****************************************************************

  wire dclk_lvl;
  wire dclk_rise;
  wire wclk_lvl;
  wire wclk_rise;
  wire div_flush;
  wire [4:0] data_half;
  wire [4:0] word_half;

  assign div_flush = power_down | wr_ctrl;

  // PLL on: data clock follows the sample clock; off: divided down from the DAC rate.
  assign data_half = pll_en ? 5'h01 : half_count(interp_sel, zero_stuff); // see (R1) (R17) (R18)

  // The word clock runs twice as fast as the per-channel clock.
  assign word_half = pll_en ? 5'h00 : (half_count(interp_sel, zero_stuff) >> 1); // see (R15)

  dcc_rate_divider u_data_div (
    .mclk(mclk),
    .rst(rst),
    .flush(div_flush),
    .half_tick(samp_half),
    .half_count(data_half),
    .clk_q(dclk_lvl),
    .rise_q(dclk_rise)
  );

  dcc_rate_divider u_word_div (
    .mclk(mclk),
    .rst(rst),
    .flush(div_flush | ~one_port),
    .half_tick(samp_half),
    .half_count(word_half),
    .clk_q(wclk_lvl),
    .rise_q(wclk_rise)
  );

  // ****************************************************************
  // Input capture
  // ****************************************************************

  wire [15:0] op_i;
  wire [15:0] op_q;
  wire op_valid;
  wire second_port_bit_fourteen;

  // In one-port mode bit 14 of port two is the channel select input.
  assign second_port_bit_fourteen = port2_in[14]; // see (R13)

  dcc_one_port_demux u_demux (
    .mclk(mclk),
    .rst(rst),
    .flush(div_flush | ~one_port),
    .capture(wclk_rise),
    .word_in(port1_in),
    .channel_select_in(second_port_bit_fourteen),
    .sel_invert(sel_invert),
    .q_first(q_first),
    .i_word_q(op_i),
    .q_word_q(op_q),
    .pair_valid_q(op_valid)
  );

  // Two-port words are taken on each data clock rise; one-port pairs come from the splitter.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      i_word <= 16'h0000;
      q_word <= 16'h0000;
      word_valid <= 1'b0;
    end else if (power_down) begin
      i_word <= 16'h0000;
      q_word <= 16'h0000;
      word_valid <= 1'b0;
    end else if (one_port) begin
      if (op_valid) begin
        i_word <= op_i; // see (R14)
        q_word <= op_q;
      end
      word_valid <= op_valid;
    end else begin
      if (dclk_rise) begin
        i_word <= port1_in; // see (R10)
        q_word <= port2_in;
      end
      word_valid <= dclk_rise;
    end
  end

  // ****************************************************************
  // Pin steering and power states
  // ****************************************************************

  wire pin_src;

  // PLL on picks lock or data clock; PLL off always offers the data clock.
  assign pin_src = (pll_en & ~lock_or_clock) ? locked_q : dclk_lvl; // see (R3) (R12)

  // The select bit sends the chosen signal to the lock pin or the readback pin.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      lock_clock_pin <= 1'b0;
      serial_readback_pin <= 1'b0;
      serial_readback_oe_n <= 1'b1;
      second_port_bit_fifteen <= 1'b0;
      second_port_bit_fifteen_oe_n <= 1'b1;
      dac_output_on <= 1'b0;
      digital_active <= 1'b0;
    end else begin
      lock_clock_pin <= ~power_down & ~clk_to_readback & pin_src; // see (R11) (R12)
      serial_readback_pin <= ~power_down & clk_to_readback & pin_src;
      serial_readback_oe_n <= ~clk_to_readback;
      second_port_bit_fifteen <= ~power_down & one_port & wclk_lvl; // see (R13) (R15)
      second_port_bit_fifteen_oe_n <= ~one_port;
      dac_output_on <= ~sleep & ~power_down; // see (R7) (R8)
      digital_active <= ~power_down; // see (R8)
    end
  end

endmodule

// ---- sim/dcc_src_model.sv ----
// Behavioural transmit data source and sample clock source for the clock control block.
`timescale 1ns/100ps
module dcc_src_model (
  input wire mclk,
  input wire dclk,
  input wire one_port,
  output wire sample_clock_input,
  output wire [15:0] port1_in,
  output wire [15:0] port2_in
);
  // ***********************************
  // Sample clock and word source
  // ***********************************
  logic [15:0] cnt_q = 16'h0;
  logic [1:0] div_q = 2'h0;
  logic dclk_q = 1'b0;
  // The sample clock is a quarter of the system clock, a data rate that every PLL setting used accepts.
  assign sample_clock_input = div_q[1];
  // New words follow each capture rise, so both ports stand a whole data period.
  always @(posedge mclk) begin
    div_q <= div_q + 2'h1;
    dclk_q <= dclk;
    if (dclk && !dclk_q) begin
      cnt_q <= cnt_q + 16'h1;
    end
  end
  // Two-port words are complements; one-port puts the channel select on bit 14.
  assign port1_in = cnt_q;
  assign port2_in = one_port ? {1'b0, cnt_q[0], 14'h0} : ~cnt_q;
endmodule

// ---- sim/dcc_top_assertions.sv ----
// Concurrent checks on the ports of the clock control block.
`timescale 1ns/100ps
module dcc_top_chk #(
  parameter [15:0] LOCK_EDGES = 16'h0100
) (
  input wire mclk,
  input wire rst,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire lock_clock_pin,
  input wire serial_readback_pin,
  input wire serial_readback_oe_n,
  input wire second_port_bit_fifteen,
  input wire second_port_bit_fifteen_oe_n,
  input wire word_valid,
  input wire [3:0] rate_strobe,
  input wire dac_output_on,
  input wire digital_active
);
  // ***********************************
  // Bus and output relations
  // ***********************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take; hsel && hready && htrans[1]; endsequence
  sequence s_wait; !hreadyout ##1 hreadyout; endsequence
  property p_rd_wait; s_take ##0 !hwrite |=> s_wait; endproperty
  property p_wr_nowait; s_take ##0 hwrite |=> hreadyout; endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_pd_data; !digital_active |-> !dac_output_on && !word_valid && rate_strobe == 4'h0; endproperty
  property p_pd_pins; !digital_active |-> !lock_clock_pin && !serial_readback_pin && !second_port_bit_fifteen;
  endproperty
  property p_strobe_sync; rate_strobe[0] |-> rate_strobe == 4'hf; endproperty
  property p_word_pulse; word_valid |=> !word_valid; endproperty
  property p_rb_drive; serial_readback_pin |-> !serial_readback_oe_n; endproperty
  property p_wc_drive; second_port_bit_fifteen |-> !second_port_bit_fifteen_oe_n; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_okay: assert property (p_okay) else $error("error response");
  a_pd_data: assert property (p_pd_data) else $error("data active in power-down");
  a_pd_pins: assert property (p_pd_pins) else $error("pins active in power-down");
  a_strobe_sync: assert property (p_strobe_sync) else $error("rate strobes not aligned");
  a_word_pulse: assert property (p_word_pulse) else $error("word valid too long");
  a_rb_drive: assert property (p_rb_drive) else $error("readback pin high undriven");
  a_wc_drive: assert property (p_wc_drive) else $error("word clock high undriven");
endmodule
bind dcc_top dcc_top_chk #(.LOCK_EDGES(LOCK_EDGES)) u_dcc_top_chk (.mclk(mclk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .lock_clock_pin(lock_clock_pin), .serial_readback_pin(serial_readback_pin),
  .serial_readback_oe_n(serial_readback_oe_n), .second_port_bit_fifteen(second_port_bit_fifteen),
  .second_port_bit_fifteen_oe_n(second_port_bit_fifteen_oe_n), .word_valid(word_valid),
  .rate_strobe(rate_strobe), .dac_output_on(dac_output_on), .digital_active(digital_active));

// ---- sim/dcc_top_tb_top.sv ----
// Testbench for the clock control block: registers, clock modes, pin routing and input ports.
`timescale 1ns/100ps
`include "dcc_consts.vh"
module dcc_top_tb_top;
  // ***********************************
  // Signals, design and source model
  // ***********************************
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic one_port = 1'b0;
  logic [1:0] psel = 2'h0;
  logic rdy_s = 1'b1;
  logic [31:0] rd_s = 32'h0;
  logic [31:0] rdat;
  int n_mismatch = 0;
  int n_tests = 0;
  int n;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq, sample_clock_input, lock_clock_pin, serial_readback_pin, serial_readback_oe_n;
  wire second_port_bit_fifteen, second_port_bit_fifteen_oe_n, word_valid, dac_output_on, digital_active;
  wire [15:0] port1_in, port2_in, i_word, q_word;
  wire [3:0] rate_strobe;
  wire pin = (psel == 2'h0) ? lock_clock_pin : (psel == 2'h1) ? serial_readback_pin : second_port_bit_fifteen;
  wire dclk = one_port ? second_port_bit_fifteen : (lock_clock_pin | serial_readback_pin);
  // Rows: control value, expected ratio field, expected data clock period in system cycles.
  logic [31:0] rows [0:8] = '{32'h0000_0004, 32'h0002_0008, 32'h0024_0020, 32'h0006_0020, 32'h0409_0204,
    32'h040b_0404, 32'h0431_0804, 32'h0419_0804, 32'h0407_0804};
  // The system clock toggles every half period of 4 ns.
  always #4 mclk = ~mclk;
  // Bus answers are taken just before the edge that samples them.
  always @(negedge mclk) begin
    rdy_s = hreadyout;
    rd_s = hrdata;
  end
  dcc_top #(.LOCK_EDGES(16'h0004)) u_dcc_top (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .sample_clock_input(sample_clock_input),
    .port1_in(port1_in), .port2_in(port2_in), .lock_clock_pin(lock_clock_pin),
    .serial_readback_pin(serial_readback_pin), .serial_readback_oe_n(serial_readback_oe_n),
    .second_port_bit_fifteen(second_port_bit_fifteen), .second_port_bit_fifteen_oe_n(second_port_bit_fifteen_oe_n),
    .i_word(i_word), .q_word(q_word), .word_valid(word_valid), .rate_strobe(rate_strobe),
    .dac_output_on(dac_output_on), .digital_active(digital_active));
  dcc_src_model u_dcc_src_model (.mclk(mclk), .dclk(dclk), .one_port(one_port),
    .sample_clock_input(sample_clock_input), .port1_in(port1_in), .port2_in(port2_in));
  // ***********************************
  // Tasks
  // ***********************************
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      n_tests++;
      if (g !== e) begin
        n_mismatch++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // One single AHB-Lite transfer: address phase, then data phase, each held until ready.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge mclk); while (rdy_s !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (rdy_s !== 1'b1);
      rdat = rd_s;
      #1;
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(rdat & m, e);
    end
  endtask
  task tick(input int k);
    begin
      repeat (k) @(posedge mclk);
      #1;
    end
  endtask
  // Measures one full period of the selected pin, skipping the first partial one and the first full one.
  task per(output int p);
    int k;
    int t;
    logic q;
    begin
      p = 0;
      q = pin;
      k = 0;
      for (t = 0; t < 2000 && k < 3; t++) begin
        tick(1);
        if (pin && !q) k++;
        q = pin;
        if (k == 2) p++;
      end
    end
  endtask
  task wwv;
    int t;
    begin
      t = 0;
      do begin tick(1); t++; end while (word_valid !== 1'b1 && t < 500);
      chk({31'h0, word_valid}, 32'h1);
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  // The watchdog ends a hung run well after all tests should be done.
  initial begin
    #300000;
    n_mismatch++;
    stop_test;
  end
  // ***********************************
  // Test sequence
  // ***********************************
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    chk({30'h0, dac_output_on, digital_active}, 32'h3);
    rc(`DCC_ADDR_CTRL, 32'hffff_ffff, 32'h0);
    rc(`DCC_ADDR_STATUS, 32'hffff_ffff, 32'h0);
    rc(`DCC_ADDR_INT_STATUS, 32'hffff_ffff, 32'h0);
    rc(`DCC_ADDR_INT_MASK, 32'hffff_ffff, 32'h0);
    bus(1'b1, 8'h10, 32'h5a5a_5a5a);
    rc(8'h10, 32'hffff_ffff, 32'h0);
    $display("reset and map test done");
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, `DCC_ADDR_CTRL, {16'h0, rows[i][31:16]});
      rc(`DCC_ADDR_STATUS, 32'hff00, {16'h0, rows[i][15:8], 8'h0});
      per(n);
      chk(n, {24'h0, rows[i][7:0]});
      wwv;
      chk({16'h0, i_word ^ q_word}, 32'h0000_ffff);
    end
    $display("clock mode rows done");
    bus(1'b1, `DCC_ADDR_CTRL, 32'h0);
    bus(1'b1, `DCC_ADDR_INT_STATUS, 32'h3);
    bus(1'b1, `DCC_ADDR_INT_MASK, 32'h1);
    bus(1'b1, `DCC_ADDR_CTRL, 32'h9);
    rc(`DCC_ADDR_STATUS, 32'h1, 32'h0);
    tick(64);
    rc(`DCC_ADDR_STATUS, 32'h1, 32'h1);
    chk({30'h0, lock_clock_pin, irq}, 32'h3);
    rc(`DCC_ADDR_INT_STATUS, 32'h3, 32'h1);
    bus(1'b1, `DCC_ADDR_INT_MASK, 32'h0);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, `DCC_ADDR_INT_MASK, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `DCC_ADDR_INT_STATUS, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, `DCC_ADDR_CTRL, 32'h209);
    tick(2);
    chk({29'h0, serial_readback_pin, serial_readback_oe_n, lock_clock_pin}, 32'h4);
    bus(1'b1, `DCC_ADDR_CTRL, 32'h200);
    rc(`DCC_ADDR_INT_STATUS, 32'h2, 32'h2);
    psel = 2'h1;
    per(n);
    chk(n, 32'h4);
    $display("lock, interrupt and routing test done");
    psel = 2'h0;
    bus(1'b1, `DCC_ADDR_CTRL, 32'h800);
    tick(2);
    chk({30'h0, dac_output_on, digital_active}, 32'h1);
    per(n);
    chk(n, 32'h4);
    bus(1'b1, `DCC_ADDR_CTRL, 32'h0);
    tick(2);
    chk({31'h0, dac_output_on}, 32'h1);
    bus(1'b1, `DCC_ADDR_CTRL, 32'h1000);
    tick(2);
    chk({30'h0, dac_output_on, digital_active}, 32'h0);
    rc(`DCC_ADDR_CTRL, 32'h1fff, 32'h1000);
    bus(1'b1, `DCC_ADDR_CTRL, 32'h0);
    tick(64);
    // Over 64 cycles the sample clock rises 16 times: strobe counts 16, 8, 4 and 2.
    rdat = 32'h0;
    repeat (64) begin
      tick(1);
      rdat = rdat + {7'h0, rate_strobe[3], 7'h0, rate_strobe[2], 7'h0, rate_strobe[1], 7'h0, rate_strobe[0]};
    end
    chk(rdat, 32'h1008_0402);
    $display("sleep and power-down test done");
    one_port = 1'b1;
    psel = 2'h2;
    bus(1'b1, `DCC_ADDR_CTRL, 32'h42);
    tick(2);
    chk({31'h0, second_port_bit_fifteen_oe_n}, 32'h0);
    per(n);
    chk(n, 32'h4);
    wwv;
    chk({30'h0, i_word[0], q_word[0]}, 32'h1);
    bus(1'b1, `DCC_ADDR_CTRL, 32'hc2);
    wwv;
    wwv;
    chk({30'h0, i_word[0], q_word[0]}, 32'h2);
    bus(1'b1, `DCC_ADDR_CTRL, 32'h142);
    wwv;
    wwv;
    chk({30'h0, i_word[0], q_word[0]}, 32'h1);
    bus(1'b1, `DCC_ADDR_CTRL, 32'h43);
    per(n);
    chk(n, 32'h2);
    $display("one-port test done");
    stop_test;
  end
endmodule
